// ### inc/fspc_pkg.sv
package fspc_pkg;
    // Control byte bit positions
    localparam int CTL_EN = 0;
    localparam int CTL_ERASE = 1;
    localparam int CTL_WRITE = 2;
    localparam int CTL_LOCK = 3;
    localparam int CTL_REEN = 4;
    localparam int CTL_SIG = 5;
    localparam int CTL_BUSY = 6;
    localparam logic [7:0] CTL_RESET = 8'h00;
    // Command windows in CPU cycles
    localparam logic [2:0] WIN_SPM = 3'h4;
    localparam logic [2:0] WIN_LPM = 3'h3;
    // Flash geometry
    localparam int PC_W = 12;
    localparam int WORD_W = 5;
    localparam int PAGE_W = 7;
    localparam logic [PAGE_W-1:0] RWW_PAGES = 7'h60;
    localparam logic [PC_W-1:0] RWW_LAST = 12'hBFF;
    localparam logic [PC_W-1:0] HALTING_SECTION_FIRST = 12'hC00;
    // Boot section start per boot-size code
    localparam logic [PC_W-1:0] BOOT_11 = 12'hF80;
    localparam logic [PC_W-1:0] BOOT_10 = 12'hF00;
    localparam logic [PC_W-1:0] BOOT_01 = 12'hE00;
    localparam logic [PC_W-1:0] BOOT_00 = 12'hC00;
    // Signature row pointer addresses
    localparam logic [12:0] SIG_ADDR_0 = 13'h0000;
    localparam logic [12:0] SIG_ADDR_CAL = 13'h0001;
    localparam logic [12:0] SIG_ADDR_1 = 13'h0002;
    localparam logic [12:0] SIG_ADDR_2 = 13'h0004;
    localparam logic [7:0] SIG_RESERVED = 8'hFF;
    // Programming time, timed by the RC oscillator tick
    localparam longint PROG_MIN_NS = 3700000;
    localparam longint PROG_MAX_NS = 4500000;
    localparam longint RC_TICK_NS = 1000;
    localparam int PROG_TICKS_MIN = int'((PROG_MIN_NS + RC_TICK_NS - 1) / RC_TICK_NS);
    localparam int PROG_TICKS_MAX = int'(PROG_MAX_NS / RC_TICK_NS);
    localparam int TICK_W = 16;
    localparam logic [15:0] ERASED = 16'hFFFF;
    localparam logic [5:0] LOCK_RESET = 6'h3F;
    // Controller register byte offsets
    localparam logic [4:0] REG_ZPTR = 5'h00;
    localparam logic [4:0] REG_DATA = 5'h04;
    localparam logic [4:0] REG_CMD = 5'h08;
    localparam logic [4:0] REG_STATUS = 5'h0C;
    localparam logic [4:0] REG_FETCH = 5'h10;
    localparam int CMD_SPM = 8;
    localparam int CMD_NOINSTR = 9;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// ### inc/fspc_if.sv
interface fspc_if;
    logic ctrl_wr;
    logic [7:0] ctrl_wdata;
    logic [7:0] ctrl_rdata;
    logic lpm;
    logic spm;
    logic [15:0] z_ptr;
    logic [15:0] spm_data;
    logic [7:0] lpm_data;
    logic lpm_valid;
    logic fetch_req;
    logic [11:0] fetch_addr;
    logic [15:0] fetch_data;
    logic fetch_valid;
    logic fetch_blocked;
    logic cpu_halt;

    modport core (
        output ctrl_wr, ctrl_wdata, lpm, spm, z_ptr, spm_data, fetch_req, fetch_addr,
        input ctrl_rdata, lpm_data, lpm_valid, fetch_data, fetch_valid, fetch_blocked, cpu_halt
    );
    modport flash (
        input ctrl_wr, ctrl_wdata, lpm, spm, z_ptr, spm_data, fetch_req, fetch_addr,
        output ctrl_rdata, lpm_data, lpm_valid, fetch_data, fetch_valid, fetch_blocked, cpu_halt
    );
endinterface

// ### core/fspc_flash.sv
// Functional notes
// [R1] LPM within three cycles returns signature byte
// [R2] Signature arm bits clear after read or timeout
// [R3] Unarmed LPM reads program flash normally
// [R4] Addresses 0,2,4 give identification bytes
// [R5] Address 1 gives RC calibration byte
// [R6] Other signature addresses are reserved
// [R7] Reset never aborts a running flash write
// [R8] Programming time counted from RC tick
// [R9] Each operation lasts 3.7 to 4.5 ms
// [R10] Boot size code selects top boot section
// [R11] Pages below 0xC00 concurrent, above halting
// [R12] 12-bit PC, 32-word pages
// [R13] Page number from pointer bits 12:6
// [R14] Pointer bits 5:1 select buffer word
// [R15] Pointer bits 15:13 ignored
// [R16] Pointer bit 0 selects byte for LPM
// [R17] Software polls enable bit before next command
// [R18] Software waits EEPROM idle, then writes, stores
// [R19] Only halting-section code fetched while programming
// [R20] Concurrent-section write sets busy until reenable; the code also clears busy on a page-buffer load SPM
// [R21] Small down-counter times the command window
//
// The AHB-Lite interface to the registers and the placing of the registers were chosen for this implementation.
module fspc_flash
    import fspc_pkg::*;
#(
    parameter int PROG_TICKS = fspc_pkg::PROG_TICKS_MIN,
    parameter logic [7:0] SIG_BYTE_0 = 8'h5A,  // Arbitrary identification value
    parameter logic [7:0] SIG_BYTE_1 = 8'hA5,  // Arbitrary identification value
    parameter logic [7:0] SIG_BYTE_2 = 8'h3C,  // Arbitrary identification value
    parameter logic [7:0] RC_CAL = 8'h80
)(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic por_n,
    input wire logic ce,
    input wire logic rc_tick,
    input wire logic [1:0] boot_size,
    output logic [11:0] boot_reset_addr,
    fspc_if.flash bus
);
    import fspc_pkg::*;

    if (PROG_TICKS < PROG_TICKS_MIN || PROG_TICKS > PROG_TICKS_MAX || PROG_TICKS >= 65536)
    begin : g_bad_ticks
        $error("PROG_TICKS outside programming time");
    end

    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_PROG = 2'b01, ST_COMMIT = 2'b11} fspc_st_t;
    typedef enum logic [1:0] {OP_ERASE = 2'b00, OP_WRITE = 2'b01, OP_LOCK = 2'b10} fspc_op_t;

    logic [15:0] mem_q [0:(1<<PC_W)-1];
    logic [15:0] buf_q [0:(1<<WORD_W)-1];
    logic [5:0] arm_q;
    logic [2:0] win_q;
    fspc_st_t st_q;
    fspc_op_t op_q;
    logic [PAGE_W-1:0] page_q;
    logic [TICK_W-1:0] tick_q;
    logic [WORD_W-1:0] idx_q;
    logic sec_busy_q;
    logic [5:0] lock_q;
    logic [7:0] spm_lock_q;
    logic halt_q;
    logic [7:0] ctrl_rdata_q;
    logic [7:0] lpm_data_q;
    logic lpm_valid_q;
    logic [15:0] fetch_data_q;
    logic fetch_valid_q;
    logic fetch_blocked_q;
    logic [11:0] boot_q;

    logic armed;
    logic lpm_ok;
    logic spm_ok;
    logic busy;
    logic start_op;
    logic load_word;
    logic reenable;
    logic [12:0] z_eff;
    logic [PAGE_W-1:0] z_page;
    logic [PC_W-1:0] commit_addr;
    logic [7:0] sig_byte;
    logic [15:0] rd_word;

    assign busy = (st_q != ST_IDLE);
    assign armed = arm_q[CTL_EN] && (win_q != 3'h0);
    assign z_eff = bus.z_ptr[12:0];                       // see [R15]
    assign z_page = z_eff[12:6];                          // see [R13]
    assign lpm_ok = armed && (win_q > WIN_SPM - WIN_LPM);  // see [R1]
    assign spm_ok = armed && !arm_q[CTL_SIG];
    assign start_op = bus.spm && spm_ok && !busy &&
                      (arm_q[CTL_ERASE] || arm_q[CTL_WRITE] || arm_q[CTL_LOCK]);
    assign load_word = bus.spm && spm_ok && !busy && (arm_q[4:1] == 4'h0);
    assign reenable = bus.spm && spm_ok && !busy && arm_q[CTL_REEN];
    assign commit_addr = {page_q, idx_q};                 // see [R12]

    always_comb
    begin
        case (z_eff)                                      // see [R4] [R5] [R6]
            SIG_ADDR_0: sig_byte = SIG_BYTE_0;
            SIG_ADDR_1: sig_byte = SIG_BYTE_1;
            SIG_ADDR_2: sig_byte = SIG_BYTE_2;
            SIG_ADDR_CAL: sig_byte = RC_CAL;
            default: sig_byte = SIG_RESERVED;
        endcase
    end

    assign rd_word = mem_q[z_eff[12:1]];

    // Armed command bits and their timed window
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            arm_q <= 6'h00;
            win_q <= 3'h0;
        end
        else if (ce)
        begin
            if (bus.ctrl_wr && !busy && bus.ctrl_wdata[CTL_EN])
            begin
                arm_q <= bus.ctrl_wdata[5:0];
                win_q <= WIN_SPM;                         // see [R21]
            end
            else if ((bus.lpm && lpm_ok) || (bus.spm && spm_ok))
            begin
                arm_q <= 6'h00;                           // see [R2]
                win_q <= 3'h0;
            end
            else if (win_q != 3'h0)
            begin
                win_q <= win_q - 3'h1;
                if (win_q == 3'h1 || (arm_q[CTL_SIG] && win_q == WIN_SPM - WIN_LPM + 3'h1))
                    arm_q <= 6'h00;                       // see [R2] [R21]
            end
        end
    end

    // Load instruction answer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lpm_data_q <= 8'h00;
            lpm_valid_q <= 1'b0;
        end
        else if (ce)
        begin
            lpm_valid_q <= bus.lpm;
            if (bus.lpm)
            begin
                if (lpm_ok && arm_q[CTL_SIG])
                    lpm_data_q <= sig_byte;               // see [R1]
                else if (lpm_ok && arm_q[CTL_LOCK])
                    lpm_data_q <= {2'b11, lock_q};
                else if (sec_busy_q && z_eff[12:1] <= RWW_LAST)
                    lpm_data_q <= SIG_RESERVED;           // see [R20]
                else
                    lpm_data_q <= z_eff[0] ? rd_word[15:8] : rd_word[7:0]; // see [R3] [R16]
            end
        end
    end

    // Programming engine, reset only at power-up so a write survives hresetn
    always_ff @(posedge hclk or negedge por_n)            // see [R7]
    begin
        if (!por_n)
        begin
            st_q <= ST_IDLE;
            op_q <= OP_ERASE;
            page_q <= '0;
            tick_q <= '0;
            idx_q <= '0;
            sec_busy_q <= 1'b0;
            lock_q <= LOCK_RESET;
            spm_lock_q <= 8'hFF;
            halt_q <= 1'b0;
        end
        else if (ce)
        begin
            case (st_q)
                ST_IDLE:
                begin
                    if (start_op)
                    begin
                        st_q <= ST_PROG;
                        tick_q <= '0;
                        idx_q <= '0;
                        page_q <= z_page;
                        spm_lock_q <= bus.spm_data[7:0];
                        if (arm_q[CTL_LOCK])
                            op_q <= OP_LOCK;
                        else if (arm_q[CTL_WRITE])
                            op_q <= OP_WRITE;
                        else
                            op_q <= OP_ERASE;
                        if (!arm_q[CTL_LOCK] && z_page < RWW_PAGES)
                            sec_busy_q <= 1'b1;           // see [R11] [R20]
                        else if (!arm_q[CTL_LOCK])
                            halt_q <= 1'b1;               // see [R19]
                    end
                    else if (reenable || load_word)
                        sec_busy_q <= 1'b0;               // see [R20]
                end
                ST_PROG:
                begin
                    if (rc_tick)
                        tick_q <= tick_q + 16'h0001;      // see [R8]
                    if (tick_q == TICK_W'(PROG_TICKS))    // see [R9]
                        st_q <= ST_COMMIT;
                end
                ST_COMMIT:
                begin
                    idx_q <= idx_q + 5'h01;
                    if (op_q == OP_LOCK || idx_q == 5'h1F)
                    begin
                        st_q <= ST_IDLE;
                        halt_q <= 1'b0;
                        if (op_q == OP_LOCK)
                            lock_q <= lock_q & spm_lock_q[5:0];
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // Flash array and page buffer updates, one word per commit cycle
    always_ff @(posedge hclk)
    begin
        if (ce)
        begin
            if (st_q == ST_COMMIT && op_q == OP_ERASE)
                mem_q[commit_addr] <= ERASED;
            else if (st_q == ST_COMMIT && op_q == OP_WRITE)
                mem_q[commit_addr] <= buf_q[idx_q];
            if (st_q == ST_COMMIT && op_q == OP_WRITE)
                buf_q[idx_q] <= ERASED;
            else if (load_word)
                buf_q[z_eff[5:1]] <= bus.spm_data;        // see [R14]
        end
    end

    // Status readback, fetch port and boot address
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_rdata_q <= CTL_RESET;
            fetch_data_q <= 16'h0000;
            fetch_valid_q <= 1'b0;
            fetch_blocked_q <= 1'b0;
            boot_q <= BOOT_00;
        end
        else if (ce)
        begin
            ctrl_rdata_q <= {1'b0, sec_busy_q, arm_q[CTL_SIG], arm_q[4:1],
                             arm_q[CTL_EN] || busy};      // see [R17]
            fetch_valid_q <= bus.fetch_req;
            if (bus.fetch_req)
            begin
                fetch_blocked_q <= halt_q || (sec_busy_q && bus.fetch_addr <= RWW_LAST); // see [R19]
                fetch_data_q <= mem_q[bus.fetch_addr];
            end
            case (boot_size)                              // see [R10]
                2'b11: boot_q <= BOOT_11;
                2'b10: boot_q <= BOOT_10;
                2'b01: boot_q <= BOOT_01;
                default: boot_q <= BOOT_00;
            endcase
        end
    end

    assign boot_reset_addr = boot_q;
    assign bus.ctrl_rdata = ctrl_rdata_q;
    assign bus.lpm_data = lpm_data_q;
    assign bus.lpm_valid = lpm_valid_q;
    assign bus.fetch_data = fetch_data_q;
    assign bus.fetch_valid = fetch_valid_q;
    assign bus.fetch_blocked = fetch_blocked_q;
    assign bus.cpu_halt = halt_q;
endmodule

// ### core/fspc_core.sv
module fspc_core
    import fspc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic eeprom_write_pending,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    fspc_if.core bus
);
    import fspc_pkg::*;

    typedef enum logic [2:0] {
        SQ_IDLE = 3'b000, SQ_POLL = 3'b001, SQ_WRCTL = 3'b011, SQ_ISSUE = 3'b010,
        SQ_WAITR = 3'b110
    } fspc_sq_t;

    fspc_sq_t sq_q;
    logic [15:0] z_q;
    logic [15:0] data_q;
    logic [9:0] cmd_q;
    logic [7:0] lpm_res_q;
    logic [15:0] fdata_q;
    logic fblk_q;
    logic [11:0] faddr_q;
    logic freq_q;
    logic ctrl_wr_q;
    logic lpm_q;
    logic spm_q;
    logic wr_pend_q;
    logic [4:0] wr_addr_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic addr_ok;
    logic wr_now;
    logic [31:0] rd_mux;

    assign addr_ok = hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD;
    assign wr_now = wr_pend_q;

    always_comb
    begin
        case (haddr[4:0])
            REG_ZPTR: rd_mux = {16'h0000, z_q};
            REG_DATA: rd_mux = {16'h0000, data_q};
            REG_CMD: rd_mux = {22'h000000, cmd_q};
            REG_STATUS: rd_mux = {14'h0000, bus.cpu_halt, sq_q != SQ_IDLE, lpm_res_q,
                                  bus.ctrl_rdata};
            REG_FETCH: rd_mux = {15'h0000, fblk_q, fdata_q};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Bus slave: zero wait states, writes land in the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata_q <= 32'h00000000;
            hreadyout_q <= 1'b0;
            wr_pend_q <= 1'b0;
            wr_addr_q <= 5'h00;
        end
        else if (ce)
        begin
            hreadyout_q <= 1'b1;
            wr_pend_q <= addr_ok && hwrite;
            wr_addr_q <= haddr[4:0];
            if (addr_ok && !hwrite)
                hrdata_q <= rd_mux;
        end
    end

    // Software-written registers and the command sequencer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sq_q <= SQ_IDLE;
            z_q <= 16'h0000;
            data_q <= 16'h0000;
            cmd_q <= 10'h000;
            lpm_res_q <= 8'h00;
            faddr_q <= 12'h000;
            freq_q <= 1'b0;
            fdata_q <= 16'h0000;
            fblk_q <= 1'b0;
            ctrl_wr_q <= 1'b0;
            lpm_q <= 1'b0;
            spm_q <= 1'b0;
        end
        else if (ce)
        begin
            ctrl_wr_q <= 1'b0;
            lpm_q <= 1'b0;
            spm_q <= 1'b0;
            freq_q <= 1'b0;
            if (wr_now && wr_addr_q == REG_ZPTR && sq_q == SQ_IDLE)
                z_q <= hwdata[15:0];
            if (wr_now && wr_addr_q == REG_DATA && sq_q == SQ_IDLE)
                data_q <= hwdata[15:0];
            if (wr_now && wr_addr_q == REG_FETCH && !freq_q)
            begin
                faddr_q <= hwdata[11:0];
                freq_q <= 1'b1;
            end
            if (bus.fetch_valid)
            begin
                fdata_q <= bus.fetch_data;
                fblk_q <= bus.fetch_blocked;
            end
            if (bus.lpm_valid)
                lpm_res_q <= bus.lpm_data;
            case (sq_q)
                SQ_IDLE:
                    if (wr_now && wr_addr_q == REG_CMD)
                    begin
                        cmd_q <= hwdata[9:0];
                        sq_q <= SQ_POLL;
                    end
                SQ_POLL:
                    if (!bus.ctrl_rdata[CTL_EN] && !eeprom_write_pending)  // see [R17] [R18]
                    begin
                        ctrl_wr_q <= 1'b1;
                        sq_q <= SQ_WRCTL;
                    end
                SQ_WRCTL:
                begin
                    if (!cmd_q[CMD_NOINSTR])
                    begin
                        spm_q <= cmd_q[CMD_SPM];          // see [R18]
                        lpm_q <= !cmd_q[CMD_SPM];         // see [R1]
                    end
                    sq_q <= SQ_ISSUE;
                end
                SQ_ISSUE:
                    sq_q <= (lpm_q) ? SQ_WAITR : SQ_IDLE;
                SQ_WAITR:
                    if (bus.lpm_valid)
                        sq_q <= SQ_IDLE;
                default: sq_q <= SQ_IDLE;
            endcase
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = 1'b0;
    assign bus.ctrl_wr = ctrl_wr_q;
    assign bus.ctrl_wdata = cmd_q[7:0];
    assign bus.lpm = lpm_q;
    assign bus.spm = spm_q;
    assign bus.z_ptr = (cmd_q[CMD_SPM]) ? {z_q[15:1], 1'b0} : z_q;  // see [R16] [R14]
    assign bus.spm_data = data_q;
    assign bus.fetch_req = freq_q;
    assign bus.fetch_addr = faddr_q;
endmodule

// ### tb/fspc_props.sv
module fspc_props
    import fspc_pkg::*;
#(
    parameter int PROG_TICKS = 3700,
    parameter logic [7:0] SIG_BYTE_0 = 8'h5A,
    parameter logic [7:0] SIG_BYTE_1 = 8'hA5,
    parameter logic [7:0] SIG_BYTE_2 = 8'h3C,
    parameter logic [7:0] RC_CAL = 8'h80
)(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_wdata,
    input wire logic [7:0] ctrl_rdata,
    input wire logic lpm,
    input wire logic spm,
    input wire logic [15:0] z_ptr,
    input wire logic [7:0] lpm_data,
    input wire logic lpm_valid,
    input wire logic cpu_halt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] halt_cnt_q;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Length of the current halt, kept across a core reset
    always_ff @(posedge hclk)
    begin
        halt_cnt_q <= cpu_halt ? halt_cnt_q + 16'h1 : 16'h0;
    end

    lpm_answer_a: assert property (lpm |=> lpm_valid)
        else $error("load not answered");
    valid_cause_a: assert property (lpm_valid |-> $past(lpm))
        else $error("answer without load");
    sig_id_a: assert property (ctrl_wr && ctrl_wdata == 8'h21 && !ctrl_rdata[0]
        ##1 lpm && z_ptr[12:0] == 13'h0000 |=> lpm_data == SIG_BYTE_0)
        else $error("identification byte wrong");
    sig_cal_a: assert property (ctrl_wr && ctrl_wdata == 8'h21 && !ctrl_rdata[0]
        ##1 lpm && z_ptr[12:0] == 13'h0001 |=> lpm_data == RC_CAL)
        else $error("calibration byte wrong");
    arm_clear_a: assert property (ctrl_wr && ctrl_wdata == 8'h21
        && !ctrl_rdata[0] |-> ##[2:6] ctrl_rdata[5:0] == 6'h00)
        else $error("signature arm not cleared");
    halt_len_a: assert property ($fell(cpu_halt)
        |-> halt_cnt_q >= PROG_TICKS && halt_cnt_q <= PROG_TICKS + 64)
        else $error("programming time out of range");
    busy_set_a: assert property (spm && ctrl_wdata[3:0] inside {4'h3, 4'h5}
        && z_ptr[12:6] < RWW_PAGES |-> ##[1:3] ctrl_rdata[6])
        else $error("section busy not set");
    halt_set_a: assert property (spm && ctrl_wdata[3:0] inside {4'h3, 4'h5}
        && z_ptr[12:6] >= RWW_PAGES |-> ##[1:3] cpu_halt)
        else $error("core not halted");
    rww_free_a: assert property (spm && ctrl_wdata[3:0] inside {4'h3, 4'h5}
        && z_ptr[12:6] < RWW_PAGES |-> !cpu_halt [*4])
        else $error("core halted for concurrent section");
    blocked_rd_a: assert property (lpm && ctrl_rdata[6] && ctrl_rdata[5:0] == 6'h00
        && !$past(ctrl_wr && ctrl_wdata[0]) && z_ptr[12:1] <= RWW_LAST |=> lpm_data == 8'hFF)
        else $error("busy section readable");
endmodule

// ### tb/fspc_tb_top.sv
module fspc_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import fspc_pkg::*;
    localparam int PT = 3700;
    localparam logic [7:0] S0 = 8'h5A; // Arbitrary identification value
    localparam logic [7:0] S1 = 8'hA5; // Arbitrary identification value
    localparam logic [7:0] S2 = 8'h3C; // Arbitrary identification value
    localparam logic [7:0] CAL = 8'h80;
    logic hclk, hresetn, por_n, eeprom_write_pending, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, boot_size;
    logic [2:0] hsize;
    logic [11:0] boot_reset_addr;
    logic rc_tick;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    int t0;

    fspc_if bus ();
    fspc_flash #(.PROG_TICKS(PT), .SIG_BYTE_0(S0), .SIG_BYTE_1(S1), .SIG_BYTE_2(S2),
        .RC_CAL(CAL)) u_fspc_flash (.hclk(hclk), .hresetn(hresetn), .por_n(por_n), .ce(1'b1),
        .rc_tick(rc_tick), .boot_size(boot_size), .boot_reset_addr(boot_reset_addr), .bus(bus));
    fspc_core u_fspc_core (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
        .eeprom_write_pending(eeprom_write_pending), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .bus(bus));
    fspc_props #(.PROG_TICKS(PT), .SIG_BYTE_0(S0), .SIG_BYTE_1(S1), .SIG_BYTE_2(S2),
        .RC_CAL(CAL)) u_fspc_props (.hclk(hclk), .hresetn(hresetn), .ctrl_wr(bus.ctrl_wr),
        .ctrl_wdata(bus.ctrl_wdata), .ctrl_rdata(bus.ctrl_rdata), .lpm(bus.lpm), .spm(bus.spm),
        .z_ptr(bus.z_ptr), .lpm_data(bus.lpm_data), .lpm_valid(bus.lpm_valid),
        .cpu_halt(bus.cpu_halt));

    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    task results;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            error_cnt++;
            results();
        end
    end

    task chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Single word transfer; read data lands in rd
    task ahb(input logic w, input logic [4:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {27'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= HSIZE_WORD;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task idle;
        do ahb(1'b0, REG_STATUS, 32'h0); while (rd[16] !== 1'b0 || rd[0] !== 1'b0);
        ahb(1'b0, REG_STATUS, 32'h0);
    endtask

    task cmd(input logic [15:0] z, input logic [15:0] d, input logic [9:0] c);
        ahb(1'b1, REG_ZPTR, {16'h0, z});
        ahb(1'b1, REG_DATA, {16'h0, d});
        ahb(1'b1, REG_CMD, {22'h0, c});
        idle();
    endtask

    task t_boot;
        for (int i = 0; i < 4; i++)
        begin
            boot_size <= i[1:0];
            repeat (3) @(posedge hclk);
            chk({20'h0, boot_reset_addr}, {20'h0, i == 0 ? BOOT_00 : i == 1 ? BOOT_01 :
                i == 2 ? BOOT_10 : BOOT_11});
        end
        $display("boot size test done");
    endtask

    task t_sig;
        logic [15:0] z [6];
        logic [7:0] e [6];
        z = '{16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'hE002, 16'h6000};
        e = '{S0, CAL, S1, S2, S1, S0};
        for (int i = 0; i < 6; i++)
        begin
            cmd(z[i], 16'h0, 10'h021);
            chk({24'h0, rd[15:8]}, {24'h0, e[i]});
            chk({24'h0, rd[7:0]}, 32'h0);
        end
        ahb(1'b0, 5'h14, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        $display("signature test done");
    endtask

    task t_expire;
        eeprom_write_pending <= 1'b1;
        ahb(1'b1, REG_CMD, 32'h221);
        repeat (8) @(posedge hclk);
        ahb(1'b0, REG_STATUS, 32'h0);
        chk({30'h0, rd[16], rd[5]}, 32'h2);
        eeprom_write_pending <= 1'b0;
        idle();
        repeat (6) @(posedge hclk);
        ahb(1'b0, REG_STATUS, 32'h0);
        chk({24'h0, rd[7:0]}, 32'h0);
        $display("arm expiry test done");
    endtask

    task fetch(input logic [11:0] a, input logic exp);
        ahb(1'b1, REG_FETCH, {20'h0, a});
        repeat (3) @(posedge hclk);
        ahb(1'b0, REG_FETCH, 32'h0);
        chk({31'h0, rd[16]}, {31'h0, exp});
    endtask

    task t_page;
        t0 = cyc;
        cmd(16'h0140, 16'h0, 10'h103);
        chk({31'h0, (cyc - t0) >= PT}, 32'h1);
        chk({31'h0, rd[6]}, 32'h1);
        cmd(16'h0146, 16'hA5C3, 10'h101);
        cmd(16'hE140, 16'h0, 10'h105);
        cmd(16'h0146, 16'h0, 10'h000);
        chk({24'h0, rd[15:8]}, 32'hFF);
        fetch(12'h0A3, 1'b1);
        fetch(12'hC00, 1'b0);
        cmd(16'h0000, 16'h0, 10'h111);
        fetch(12'h0A3, 1'b0);
        chk({16'h0, rd[15:0]}, 32'hA5C3);
        cmd(16'h0146, 16'h0, 10'h000);
        chk({24'h0, rd[15:8]}, 32'hC3);
        cmd(16'h0147, 16'h0, 10'h000);
        chk({24'h0, rd[15:8]}, 32'hA5);
        $display("page test done");
    endtask

    task t_reset;
        ahb(1'b1, REG_ZPTR, 32'h1C00);
        ahb(1'b1, REG_CMD, 32'h103);
        t0 = cyc;
        repeat (200) @(posedge hclk);
        hresetn <= 1'b0;
        rc_tick <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (18) @(posedge hclk);
        rc_tick <= 1'b1;
        repeat (2) @(posedge hclk);
        chk({31'h0, bus.cpu_halt}, 32'h1);
        while (bus.cpu_halt === 1'b1) @(posedge hclk);
        // Twenty withheld ticks must stretch the operation
        chk({31'h0, (cyc - t0) >= PT + 45}, 32'h1);
        idle();
        $display("reset during write test done");
    endtask

    initial
    begin
        hresetn = 1'b0;
        por_n = 1'b0;
        eeprom_write_pending = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h0;
        boot_size = 2'h0;
        rc_tick = 1'b1;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        por_n <= 1'b1;
        repeat (2) @(posedge hclk);
        t_boot();
        t_sig();
        t_expire();
        t_page();
        t_reset();
        results();
    end
endmodule
